// file: hw/cwgc_deadband.sv
`timescale 1ns/1ps
// Dead-band delay counter; busy while the inserted interval runs
module cwgc_deadband (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Start and length
   input wire logic start,
   input wire logic [5:0] length,
   // Status
   output logic busy
);
   import cwgc_pkg::*;

   typedef struct packed {
      logic [5:0] cnt;
      logic busy;
   } cwgc_db_state_s;

   cwgc_db_state_s s_q;
   cwgc_db_state_s s_d;

   // Reload on start, otherwise count down to zero
   always_comb begin
      s_d = s_q;
      if (start) begin
         s_d.cnt = length;
         s_d.busy = (length != 6'h00);
      end else if (s_q.cnt > 6'h01) begin
         s_d.cnt = s_q.cnt - 6'h01;
      end else begin
         s_d.cnt = 6'h00;
         s_d.busy = 1'b0;
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign busy = s_q.busy;
endmodule : cwgc_deadband

// file: hw/cwgc_defs.svh
`ifndef CWGC_DEFS_SVH
`define CWGC_DEFS_SVH
// Register byte offsets
`define CWGC_OFS_CTRL0 8'h00
`define CWGC_OFS_CTRL1 8'h04
`define CWGC_OFS_DBR 8'h08
`define CWGC_OFS_DBF 8'h0C
`define CWGC_IDX_SHUT 2'h0
`define CWGC_OFS_SHUT 8'h10
// Field positions
`define CWGC_EN_BIT 7
`define CWGC_LD_BIT 6
`define CWGC_IN_BIT 5
`define CWGC_SD_BIT 7
`define CWGC_REN_BIT 6
// Reset values
`define CWGC_SHUT_RST 8'h14
`define CWGC_MODE_RST 3'h0
// Bus answers
`define CWGC_RESP_OKAY 2'h0
`define CWGC_RESP_SLVERR 2'h2
`endif

// file: hw/cwgc_pkg.sv
package cwgc_pkg;
   typedef enum logic [2:0] {
      CWGC_STEER = 3'b000,
      CWGC_SYNC_STEER = 3'b001,
      CWGC_FWD_FULL = 3'b010,
      CWGC_REV_FULL = 3'b011,
      CWGC_HALF = 3'b100,
      CWGC_PUSH_PULL = 3'b101
   } cwgc_mode_e;

   typedef enum logic [1:0] {
      CWGC_OVR_IDLE = 2'b00,
      CWGC_OVR_HIZ = 2'b01,
      CWGC_OVR_LOW = 2'b10,
      CWGC_OVR_HIGH = 2'b11
   } cwgc_ovr_e;

   // Four output pins, enable low means driving
   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe_n;
   } cwgc_pins_s;

   typedef struct packed {
      logic [5:0] rise;
      logic [5:0] fall;
   } cwgc_dead_s;
endpackage : cwgc_pkg

// file: hw/cwgc_top.sv
// Notes on behaviour
// - Generator runs only while enable set
// - Load request applies buffers, self-clears at edge
// - Mode 101 push-pull, 100 half, 011 reverse
// - Mode 010 forward, 001 sync steer, 000 steer
// - Per-output polarity bit inverts output
// - Six-bit rising dead time
// - Six-bit falling dead time
// - Shutdown status reads one while in shutdown
// - Override B and D: high, low, hi-z
// - Code 00: B/D inactive after dead band
// - Override A and C: high, low, hi-z
// - Code 00: A/C inactive after dead band
// - Shutdown writable while disabled
// - Shutdown levels held until next rising input
// - Unimplemented bits read zero, ignore writes
// - Auto restart clears shutdown when sources low
// - Software clear only when sources all low
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "cwgc_defs.svh"
module cwgc_top (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Waveform input and active-low shutdown sources
   input wire logic wave_in,
   input wire logic shutdown_src_n,
   // Outputs A to D
   output cwgc_pkg::cwgc_pins_s pins
);
   import cwgc_pkg::*;

   typedef struct packed {
      logic aw_full;
      logic [7:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic en;
      logic ld;
      cwgc_mode_e mode;
      logic [3:0] pol;
      cwgc_dead_s dead;
      logic sd;
      logic ren;
      cwgc_ovr_e ovr_bd;
      cwgc_ovr_e ovr_ac;
      cwgc_mode_e act_mode;
      logic [3:0] act_pol;
      cwgc_dead_s act_dead;
      logic in_q;
      logic hold;
      logic dir;
      logic [3:0] raw;
      cwgc_pins_s pins;
   } cwgc_state_s;

   cwgc_state_s s_q;
   cwgc_state_s s_d;
   logic rise_ev;
   logic fall_ev;
   logic src_active;
   logic db_busy;
   logic db_start;
   logic [5:0] db_len;
   logic [7:0] rd_byte;
   logic wr_go;
   logic sd_clear_req;

   assign rise_ev = wave_in & ~s_q.in_q;
   assign fall_ev = ~wave_in & s_q.in_q;
   assign src_active = ~shutdown_src_n;
   assign db_start = s_q.en & (rise_ev | fall_ev);
   assign db_len = rise_ev ? s_q.act_dead.rise : s_q.act_dead.fall;
   assign wr_go = s_q.aw_full & s_q.w_full & ~s_q.bvalid;

   cwgc_deadband u_db (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(db_start),
      .length(db_len),
      .busy(db_busy)
   );

   // Read mux; unimplemented bits stay zero
   always_comb begin
      rd_byte = 8'h00;
      case (s_axi_araddr)
         `CWGC_OFS_CTRL0: rd_byte = {s_q.en, s_q.ld, 3'b000, s_q.mode};
         `CWGC_OFS_CTRL1: rd_byte = {2'b00, wave_in, 1'b0, s_q.pol};
         `CWGC_OFS_DBR: rd_byte = {2'b00, s_q.dead.rise};
         `CWGC_OFS_DBF: rd_byte = {2'b00, s_q.dead.fall};
         `CWGC_OFS_SHUT: rd_byte = {s_q.sd, s_q.ren, s_q.ovr_bd,
                                  s_q.ovr_ac, 2'b00};
         default: rd_byte = 8'h00;
      endcase
   end

   // Software clear of shutdown is honoured only with sources idle
   assign sd_clear_req = wr_go & s_q.aw_addr == `CWGC_OFS_SHUT &
                         s_q.w_strb[0] & ~s_q.w_data[`CWGC_SD_BIT];

   // Next-state logic: bus slave, registers, waveform engine
   always_comb begin
      logic [3:0] base;
      logic [3:0] shaped;
      base = 4'h0;
      shaped = 4'h0;
      s_d = s_q;
      s_d.in_q = wave_in;
      // Edge transfer first, so a load set in this cycle wins
      if (s_q.en && s_q.ld && (rise_ev || fall_ev)) begin
         s_d.act_mode = s_q.mode;
         s_d.act_pol = s_q.pol;
         s_d.act_dead = s_q.dead;
         s_d.ld = 1'b0;
      end
      // Address and data may arrive in either order
      if (s_axi_awvalid && !s_q.aw_full) begin
         s_d.aw_full = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.w_full) begin
         s_d.w_full = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (wr_go) begin
         s_d.aw_full = 1'b0;
         s_d.w_full = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = `CWGC_RESP_OKAY;
         if (s_q.w_strb[0]) begin
            case (s_q.aw_addr)
               `CWGC_OFS_CTRL0: begin
                  s_d.en = s_q.w_data[`CWGC_EN_BIT];
                  // Load arms only when already enabled
                  s_d.ld = s_q.w_data[`CWGC_LD_BIT] & s_q.en;
                  if (s_q.w_data[2:1] != 2'b11) begin
                     s_d.mode = cwgc_mode_e'(s_q.w_data[2:0]);
                  end
               end
               `CWGC_OFS_CTRL1: s_d.pol = s_q.w_data[3:0];
               `CWGC_OFS_DBR: s_d.dead.rise = s_q.w_data[5:0];
               `CWGC_OFS_DBF: s_d.dead.fall = s_q.w_data[5:0];
               `CWGC_OFS_SHUT: begin
                  // Accepted regardless of enable
                  if (s_q.w_data[`CWGC_SD_BIT]) begin
                     s_d.sd = 1'b1;
                  end
                  s_d.ren = s_q.w_data[`CWGC_REN_BIT];
                  s_d.ovr_bd = cwgc_ovr_e'(s_q.w_data[5:4]);
                  s_d.ovr_ac = cwgc_ovr_e'(s_q.w_data[3:2]);
               end
               default: s_d.bresp = `CWGC_RESP_SLVERR;
            endcase
         end
      end
      // Reads answer one cycle after the address is taken
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = {24'h000000, rd_byte};
         s_d.rresp = (s_axi_araddr[1:0] == 2'b00 &&
                      s_axi_araddr <= `CWGC_OFS_SHUT) ?
                     `CWGC_RESP_OKAY : `CWGC_RESP_SLVERR;
      end
      // Shutdown status: sources set, clear needs idle sources
      if (sd_clear_req && !src_active) begin
         s_d.sd = 1'b0;
      end
      if (s_q.ren && !src_active && s_q.sd) begin
         s_d.sd = 1'b0;
      end
      if (src_active) begin
         s_d.sd = 1'b1;
      end
      if (s_d.sd) begin
         s_d.hold = 1'b1;
      end else if (s_q.hold && rise_ev && s_q.en) begin
         s_d.hold = 1'b0;
      end
      if (!s_q.en) begin
         s_d.act_mode = s_q.mode;
         s_d.act_pol = s_q.pol;
         s_d.act_dead = s_q.dead;
      end
      if (s_q.en && rise_ev) begin
         s_d.dir = ~s_q.dir;
      end
      // Raw active-high waveform per mode
      case (s_q.act_mode)
         CWGC_STEER, CWGC_SYNC_STEER: base = {4{wave_in}};
         CWGC_FWD_FULL: base = {wave_in, 2'b00, 1'b1};
         CWGC_REV_FULL: base = {1'b0, 1'b1, wave_in, 1'b0};
         CWGC_HALF: base = {~wave_in, wave_in, ~wave_in, wave_in};
         CWGC_PUSH_PULL: base = {s_q.dir & wave_in, ~s_q.dir & wave_in,
                                 s_q.dir & wave_in, ~s_q.dir & wave_in};
         default: base = 4'h0;
      endcase
      // Newly rising outputs wait out the dead band
      if (db_busy || db_start) begin
         base = base & s_q.raw;
      end
      s_d.raw = base;
      shaped = base ^ s_q.act_pol;
      s_d.pins.oe_n = 4'h0;
      if (!s_q.en) begin
         s_d.pins.out = s_q.act_pol;
      end else if (s_q.hold) begin
         for (int i = 0; i < 4; i++) begin
            cwgc_ovr_e o;
            o = (i % 2 == 1) ? s_q.ovr_bd : s_q.ovr_ac;
            case (o)
               CWGC_OVR_HIGH: s_d.pins.out[i] = 1'b1;
               CWGC_OVR_LOW: s_d.pins.out[i] = 1'b0;
               CWGC_OVR_HIZ: s_d.pins.oe_n[i] = 1'b1;
               // Inactive level once dead band ends
               default: s_d.pins.out[i] = db_busy ? s_q.pins.out[i] :
                                          s_q.act_pol[i];
            endcase
         end
      end else begin
         s_d.pins.out = shaped;
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.ovr_bd <= CWGC_OVR_HIZ;
         s_q.ovr_ac <= CWGC_OVR_HIZ;
         s_q.hold <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign s_axi_awready = ~s_q.aw_full;
   assign s_axi_wready = ~s_q.w_full;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = ~s_q.rvalid;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign pins = s_q.pins;

   property p_ld_clear;
      @(posedge aclk) disable iff (!aresetn)
         s_q.en && s_q.ld && (rise_ev || fall_ev) && !wr_go |=> !s_q.ld;
   endproperty
   a_ld_clear: assert property (p_ld_clear)
      else $error("load request not cleared");

   property p_src_sets;
      @(posedge aclk) disable iff (!aresetn)
         src_active |=> s_q.sd;
   endproperty
   a_src_sets: assert property (p_src_sets)
      else $error("shutdown not set");

   property p_auto;
      @(posedge aclk) disable iff (!aresetn)
         s_q.ren && !src_active && s_q.sd && !s_axi_wvalid |=> !s_q.sd;
   endproperty
   a_auto: assert property (p_auto)
      else $error("auto restart failed");

   property p_sw_clear;
      @(posedge aclk) disable iff (!aresetn)
         sd_clear_req && src_active |=> s_q.sd;
   endproperty
   a_sw_clear: assert property (p_sw_clear)
      else $error("shutdown cleared with source active");

   property p_hold;
      @(posedge aclk) disable iff (!aresetn)
         s_q.hold && !rise_ev |=> s_q.hold;
   endproperty
   a_hold: assert property (p_hold)
      else $error("hold released without rising edge");

   property p_hiz;
      @(posedge aclk) disable iff (!aresetn)
         s_q.en && s_q.hold && s_q.ovr_ac == CWGC_OVR_HIZ
         |=> pins.oe_n[0] && pins.oe_n[2];
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("A/C not tri-stated");

   property p_high_bd;
      @(posedge aclk) disable iff (!aresetn)
         s_q.en && s_q.hold && s_q.ovr_bd == CWGC_OVR_HIGH
         |=> pins.out[1] && pins.out[3];
   endproperty
   a_high_bd: assert property (p_high_bd)
      else $error("B/D not driven high");

   property p_dis;
      @(posedge aclk) disable iff (!aresetn)
         !s_q.en |=> pins.out == $past(s_q.act_pol);
   endproperty
   a_dis: assert property (p_dis)
      else $error("disabled outputs not idle");
endmodule : cwgc_top

// file: verif/complementary_waveform_control_test.sv
`timescale 1ns/1ps
`include "cwgc_defs.svh"
module complementary_waveform_control_test;
   import cwgc_pkg::*;
   localparam logic [7:0] A_C0 = 8'(`CWGC_OFS_CTRL0);
   localparam logic [7:0] A_C1 = 8'(`CWGC_OFS_CTRL1);
   localparam logic [7:0] A_DBR = 8'(`CWGC_OFS_DBR);
   localparam logic [7:0] A_DBF = 8'(`CWGC_OFS_DBF);
   localparam logic [7:0] A_SD = `CWGC_OFS_SHUT;
   localparam logic [1:0] OK = `CWGC_RESP_OKAY;
   localparam logic [1:0] ERR = `CWGC_RESP_SLVERR;
   logic aclk, aresetn, wave_in, shutdown_src_n;
   logic [7:0] s_axi_awaddr, s_axi_araddr, v;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, gate, o, z;
   logic [1:0] s_axi_bresp, s_axi_rresp, ac, bd;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   cwgc_pins_s pins;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;

   cwgc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wave_in,
      .shutdown_src_n, .pins);
   cwgc_bridge u_bridge (.pins, .gate);

   // 125 MHz clock
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // Hang guard, far above the length of the sequence
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("miscompares=%0d checks_done=%0d", miscompares, checks_done);
      if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er = OK);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask : wr

   task automatic rc(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er = OK);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, {24'h0, d});
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask : rc

   // Pins after the registered path settles; hi-z pins hide their data
   task automatic pchk(input logic [3:0] out, input logic [3:0] oe);
      repeat (4) @(posedge aclk);
      chk({20'h0, gate, pins.out & ~pins.oe_n, pins.oe_n},
          {20'h0, out & ~oe, out & ~oe, oe});
   endtask : pchk

   // Main sequence
   initial begin
      aresetn = 1'b0;
      wave_in = 1'b0;
      shutdown_src_n = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h1;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rc(A_C0, 8'h00);
      rc(A_C1, 8'h00);
      rc(A_SD, 8'h14);
      // Every legal mode, with the unused bits set
      for (int m = 0; m < 6; m++) begin
         wr(A_C0, 8'h38 | 8'(m));
         rc(A_C0, 8'(m));
      end
      wr(A_C0, 8'h00);
      wr(A_C1, 8'hFF);
      rc(A_C1, 8'h0F);
      wave_in <= 1'b1;
      rc(A_C1, 8'h2F);
      wave_in <= 1'b0;
      wr(A_C1, 8'h05);
      pchk(4'h5, 4'h0);
      wr(A_DBR, 8'hFF);
      rc(A_DBR, 8'h3F);
      wr(A_DBF, 8'hFF);
      rc(A_DBF, 8'h3F);
      // Enable first, load request only in a later write
      wr(A_C0, 8'h80);
      wr(A_C0, 8'hC0);
      rc(A_C0, 8'hC0);
      wave_in <= 1'b1;
      repeat (3) @(posedge aclk);
      wave_in <= 1'b0;
      rc(A_C0, 8'h80);
      wr(A_C0, 8'h00);
      wr(A_SD, 8'hBF);
      rc(A_SD, 8'hBC);
      wr(A_C0, 8'h80);
      pchk(4'hF, 4'h0);
      // Each override code on each pair
      for (int c = 1; c < 4; c++) begin
         ac = 2'(c);
         bd = 2'(4 - c);
         v = {2'b10, bd, ac, 2'b00};
         o = {bd == 2'h3, ac == 2'h3, bd == 2'h3, ac == 2'h3};
         z = {bd == 2'h1, ac == 2'h1, bd == 2'h1, ac == 2'h1};
         wr(A_SD, v);
         pchk(o, z);
      end
      // Code 00 on both pairs: polarity-adjusted inactive level
      wr(A_SD, 8'h80);
      pchk(4'h5, 4'h0);
      wr(A_SD, 8'hBC);
      shutdown_src_n <= 1'b0;
      wr(A_SD, 8'h3C);
      rc(A_SD, 8'hBC);
      shutdown_src_n <= 1'b1;
      wr(A_SD, 8'h3C);
      rc(A_SD, 8'h3C);
      pchk(4'hF, 4'h0);
      // First rising input ends the hold; rising dead band masks it
      wave_in <= 1'b1;
      pchk(4'h5, 4'h0);
      repeat (70) @(posedge aclk);
      pchk(4'hA, 4'h0);
      // Half-bridge comes in through the load request at a fall
      wr(A_C0, 8'h84);
      wr(A_C0, 8'hC4);
      wave_in <= 1'b0;
      repeat (70) @(posedge aclk);
      pchk(4'hF, 4'h0);
      rc(A_C0, 8'h84);
      wr(A_SD, 8'h7C);
      shutdown_src_n <= 1'b0;
      repeat (3) @(posedge aclk);
      rc(A_SD, 8'hFC);
      shutdown_src_n <= 1'b1;
      repeat (3) @(posedge aclk);
      rc(A_SD, 8'h7C);
      rc(8'h14, 8'h00, ERR);
      wr(8'h14, 8'hFF, ERR);
      stop_test();
   end
endmodule : complementary_waveform_control_test

// file: verif/cwgc_bridge.sv
`timescale 1ns/1ps
// Gate inputs of the bridge stage; a released pin falls to the pull-down
module cwgc_bridge (
   // Pins from the generator
   input wire cwgc_pkg::cwgc_pins_s pins,
   // Gate levels seen by the bridge
   output logic [3:0] gate
);
   import cwgc_pkg::*;
   // Pull-down keeps a tri-stated switch off, never a stale high
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         gate[i] = pins.oe_n[i] ? 1'b0 : pins.out[i];
      end
   end
endmodule : cwgc_bridge
